// >>> hdl/cal_pkg.sv
// constants shared by the calendar/alarm core and its serial-bus slave
`default_nettype none
package cal_pkg;
    // serial-bus slave address (7 bit; write A2h, read A3h)
    localparam logic [6:0] SLAVE_ADDR = 7'h51;

    // register locations
    localparam logic [7:0] ADDR_SECONDS = 8'h04;
    localparam logic [7:0] ADDR_MINUTES = 8'h05;
    localparam logic [7:0] ADDR_HOURS = 8'h06;
    localparam logic [7:0] ADDR_DAYS = 8'h07;
    localparam logic [7:0] ADDR_WEEKDAYS = 8'h08;
    localparam logic [7:0] ADDR_CALENDAR_MONTH = 8'h09;
    localparam logic [7:0] ADDR_CALENDAR_YEAR = 8'h0A;
    localparam logic [7:0] ADDR_SECONDS_MATCH = 8'h0B;
    localparam logic [7:0] ADDR_MINUTES_MATCH = 8'h0C;
    localparam logic [7:0] ADDR_HOURS_MATCH = 8'h0D;

    // implemented bits of each register; the rest read zero
    localparam logic [7:0] MASK_SECONDS = 8'hFF;
    localparam logic [7:0] MASK_MINUTES = 8'h7F;
    localparam logic [7:0] MASK_HOURS = 8'h3F;
    localparam logic [7:0] MASK_DAYS = 8'h3F;
    localparam logic [7:0] MASK_WEEKDAYS = 8'h07;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    localparam logic [7:0] MASK_SEC_MATCH = 8'hFF;
    localparam logic [7:0] MASK_MIN_MATCH = 8'hFF;
    localparam logic [7:0] MASK_HOUR_MATCH = 8'hBF;

    // field positions
    localparam int COMPARE_DISABLE_BIT = 7;
    localparam int AFTERNOON_BIT = 5;

    // reset values
    localparam logic [7:0] RST_SECONDS = 8'h80;
    localparam logic [7:0] RST_MINUTES = 8'h00;
    localparam logic [7:0] RST_HOURS = 8'h00;
    localparam logic [7:0] RST_DAYS = 8'h01;
    localparam logic [2:0] RST_WEEKDAY = 3'h6;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] RST_MATCH = 8'h80;

    // counting limits, all BCD
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] BCD_SEC_MAX = 8'h59;
    localparam logic [7:0] BCD_HOUR24_MAX = 8'h23;
    localparam logic [4:0] BCD_HOUR12_ELEVEN = 5'h11;
    localparam logic [4:0] BCD_HOUR12_NOON = 5'h12;
    localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
    localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
    localparam logic [7:0] BCD_DAYS_31 = 8'h31;
    localparam logic [7:0] BCD_DAYS_30 = 8'h30;
    localparam logic [7:0] BCD_DAYS_29 = 8'h29;
    localparam logic [7:0] BCD_DAYS_28 = 8'h28;
    localparam logic [7:0] BCD_FEBRUARY = 8'h02;
    localparam logic [2:0] WEEKDAY_MAX = 3'h6;
    localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;

    // serial slave states, gray along address, ack, write and read ack; ack to read flips two bits
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b011,
        ST_WR = 3'b010,
        ST_RD = 3'b110,
        ST_RACK = 3'b111
    } cal_state_t;
endpackage
`default_nettype wire

// >>> hdl/cal_rtc.sv
// calendar, time counting and alarm match registers behind a serial-bus slave
`default_nettype none
module cal_rtc
    import cal_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // serial bus, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // timebase from the oscillator
    input wire logic tick_1hz,
    // control bits held outside this block
    input wire logic hour_mode_12,
    input wire logic alarm_irq_enable,
    input wire logic alarm_flag_clear,
    // alarm status
    output logic alarm_flag,
    output logic int_n
);
    ////////////////////////////////////////////////////////////////////////
    // helpers

    // returns {carry, next}; wraps to low after top
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top, input logic [7:0] low);
        logic [8:0] r;
        r = {1'b0, v + 8'h01};
        if (v >= top) begin
            r = {1'b1, low};
        end else if (v[3:0] >= 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        return r;
    endfunction

    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        logic [7:0] len;
        // divisible by four, year 00 included
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        len = BCD_DAYS_31;
        if (mon == BCD_FEBRUARY) begin
            len = leap ? BCD_DAYS_29 : BCD_DAYS_28;
        end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
            len = BCD_DAYS_30;
        end
        return len;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // serial slave

    logic busy, wr_stb;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    logic slave_oe_n;

    cal_serial_slave u_slave (
        .clk(clk),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_n(slave_oe_n),
        .busy(busy),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] sec_ff, min_ff, hour_ff, day_ff, mon_ff, year_ff;
    logic [2:0] wday_ff;
    logic [7:0] sec_match_ff, min_match_ff, hour_match_ff;
    logic tick_meta_ff, tick_s_ff, tick_d_ff;
    logic pending_ff, match_d_ff, flag_ff, int_n_ff, sda_out_ff, oe_n_ff;

    ////////////////////////////////////////////////////////////////////////
    // tick handling

    wire tick_pulse = tick_s_ff & ~tick_d_ff;
    // an access locks the counters; a tick meanwhile is parked
    wire inc_go = (tick_pulse | pending_ff) & ~busy;
    // a second tick during one access overwrites nothing: it is lost
    wire nxt_pending = busy & (tick_pulse | pending_ff);

    ////////////////////////////////////////////////////////////////////////
    // counting chain

    wire [8:0] sec_i = bcd_inc({1'b0, sec_ff[6:0]}, BCD_SEC_MAX, BCD_ZERO);
    wire [8:0] min_i = bcd_inc(min_ff, BCD_SEC_MAX, BCD_ZERO);
    wire [8:0] h24_i = bcd_inc(hour_ff, BCD_HOUR24_MAX, BCD_ZERO);
    wire [8:0] h12_i = bcd_inc({3'h0, hour_ff[4:0]}, {3'h0, BCD_HOUR12_NOON}, BCD_ONE);
    wire pm = hour_ff[AFTERNOON_BIT];
    wire h12_eleven = (hour_ff[4:0] == BCD_HOUR12_ELEVEN);
    // 11 -> 12 flips the half-day; 11 PM -> 12 AM carries into the day
    wire [7:0] h12_next = h12_eleven ? {2'b00, ~pm, BCD_HOUR12_NOON}
                                     : {2'b00, pm, h12_i[4:0]};
    wire [8:0] hour_i = hour_mode_12 ? {h12_eleven & pm, h12_next} : h24_i;
    wire [8:0] day_i = bcd_inc(day_ff, month_len(mon_ff, year_ff), BCD_ONE);
    wire [8:0] mon_i = bcd_inc(mon_ff, BCD_MONTH_MAX, BCD_ONE);
    wire [8:0] year_i = bcd_inc(year_ff, BCD_YEAR_MAX, BCD_ZERO);
    wire [2:0] wday_i = (wday_ff >= WEEKDAY_MAX) ? 3'h0 : wday_ff + 3'h1;

    wire go_min = inc_go & sec_i[8];
    wire go_hour = go_min & min_i[8];
    wire go_day = go_hour & hour_i[8];
    wire go_mon = go_day & day_i[8];
    wire go_year = go_mon & mon_i[8];

    ////////////////////////////////////////////////////////////////////////
    // register writes

    wire wr_sec = wr_stb & (wr_addr == ADDR_SECONDS);
    wire wr_min = wr_stb & (wr_addr == ADDR_MINUTES);
    wire wr_hour = wr_stb & (wr_addr == ADDR_HOURS);
    wire wr_day = wr_stb & (wr_addr == ADDR_DAYS);
    wire wr_wday = wr_stb & (wr_addr == ADDR_WEEKDAYS);
    wire wr_mon = wr_stb & (wr_addr == ADDR_CALENDAR_MONTH);
    wire wr_year = wr_stb & (wr_addr == ADDR_CALENDAR_YEAR);
    wire wr_smatch = wr_stb & (wr_addr == ADDR_SECONDS_MATCH);
    wire wr_mmatch = wr_stb & (wr_addr == ADDR_MINUTES_MATCH);
    wire wr_hmatch = wr_stb & (wr_addr == ADDR_HOURS_MATCH);

    // writes only happen while busy, increments only while idle
    wire [7:0] nxt_sec = wr_sec ? (wr_data & MASK_SECONDS) : (inc_go ? {sec_ff[7], sec_i[6:0]} : sec_ff);
    wire [7:0] nxt_min = wr_min ? (wr_data & MASK_MINUTES) : (go_min ? min_i[7:0] : min_ff);
    wire [7:0] nxt_hour = wr_hour ? (wr_data & MASK_HOURS) : (go_hour ? hour_i[7:0] : hour_ff);
    wire [7:0] nxt_day = wr_day ? (wr_data & MASK_DAYS) : (go_day ? day_i[7:0] : day_ff);
    wire [2:0] nxt_wday = wr_wday ? wr_data[2:0] : (go_day ? wday_i : wday_ff);
    wire [7:0] nxt_mon = wr_mon ? (wr_data & MASK_MONTH) : (go_mon ? mon_i[7:0] : mon_ff);
    wire [7:0] nxt_year = wr_year ? (wr_data & MASK_YEAR) : (go_year ? year_i[7:0] : year_ff);
    wire [7:0] nxt_sec_match = wr_smatch ? (wr_data & MASK_SEC_MATCH) : sec_match_ff;
    wire [7:0] nxt_min_match = wr_mmatch ? (wr_data & MASK_MIN_MATCH) : min_match_ff;
    wire [7:0] nxt_hour_match = wr_hmatch ? (wr_data & MASK_HOUR_MATCH) : hour_match_ff;

    ////////////////////////////////////////////////////////////////////////
    // read selection, unmapped locations read zero

    wire [7:0] rd_sel =
        (rd_addr == ADDR_SECONDS) ? sec_ff :
        (rd_addr == ADDR_MINUTES) ? min_ff :
        (rd_addr == ADDR_HOURS) ? hour_ff :
        (rd_addr == ADDR_DAYS) ? day_ff :
        (rd_addr == ADDR_WEEKDAYS) ? {5'h00, wday_ff} :
        (rd_addr == ADDR_CALENDAR_MONTH) ? mon_ff :
        (rd_addr == ADDR_CALENDAR_YEAR) ? year_ff :
        (rd_addr == ADDR_SECONDS_MATCH) ? sec_match_ff :
        (rd_addr == ADDR_MINUTES_MATCH) ? min_match_ff :
        (rd_addr == ADDR_HOURS_MATCH) ? hour_match_ff : 8'h00;
    assign rd_data = rd_sel;

    ////////////////////////////////////////////////////////////////////////
    // alarm compare

    wire dis_s = sec_match_ff[COMPARE_DISABLE_BIT];
    wire dis_m = min_match_ff[COMPARE_DISABLE_BIT];
    wire dis_h = hour_match_ff[COMPARE_DISABLE_BIT];
    wire second_compare_disable = dis_s;
    wire minute_compare_disable = dis_m;
    wire hour_compare_disable = dis_h;
    // hour field compared raw, both sides share the selected layout
    wire eq_s = (sec_match_ff[6:0] == sec_ff[6:0]);
    wire eq_m = (min_match_ff[6:0] == min_ff[6:0]);
    wire eq_h = (hour_match_ff[5:0] == hour_ff[5:0]);
    wire any_enabled = ~(second_compare_disable & minute_compare_disable & hour_compare_disable);
    wire match_now = any_enabled & (second_compare_disable | eq_s) & (minute_compare_disable | eq_m)
                     & (hour_compare_disable | eq_h);
    // edge only, so a cleared flag waits for the next entry into a match
    wire match_rise = match_now & ~match_d_ff;
    // a new match in the clearing cycle wins
    wire nxt_flag = match_rise | (flag_ff & ~alarm_flag_clear);
    wire nxt_int_n = ~(alarm_irq_enable & nxt_flag);

    assign alarm_flag = flag_ff;
    assign int_n = int_n_ff;
    assign sda_out = sda_out_ff;
    assign sda_oe_n = oe_n_ff;

    ////////////////////////////////////////////////////////////////////////
    // flops

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sec_ff <= RST_SECONDS;
            min_ff <= RST_MINUTES;
            hour_ff <= RST_HOURS;
            day_ff <= RST_DAYS;
            wday_ff <= RST_WEEKDAY;
            mon_ff <= RST_MONTH;
            year_ff <= RST_YEAR;
            sec_match_ff <= RST_MATCH;
            min_match_ff <= RST_MATCH;
            hour_match_ff <= RST_MATCH;
        end else begin
            sec_ff <= nxt_sec;
            min_ff <= nxt_min;
            hour_ff <= nxt_hour;
            day_ff <= nxt_day;
            wday_ff <= nxt_wday;
            mon_ff <= nxt_mon;
            year_ff <= nxt_year;
            sec_match_ff <= nxt_sec_match;
            min_match_ff <= nxt_min_match;
            hour_match_ff <= nxt_hour_match;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {tick_meta_ff, tick_s_ff, tick_d_ff} <= 3'h0;
            pending_ff <= 1'b0;
            match_d_ff <= 1'b0;
            flag_ff <= 1'b0;
            int_n_ff <= 1'b1;
            sda_out_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end else begin
            {tick_meta_ff, tick_s_ff, tick_d_ff} <= {tick_1hz, tick_meta_ff, tick_s_ff};
            pending_ff <= nxt_pending;
            match_d_ff <= match_now;
            flag_ff <= nxt_flag;
            int_n_ff <= nxt_int_n;
            sda_out_ff <= 1'b0;
            oe_n_ff <= slave_oe_n;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/cal_serial_slave.sv
// serial-bus slave: address match, register pointer, byte write and read
`default_nettype none
module cal_serial_slave
    import cal_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_n,
    // register side
    output logic busy,
    output logic wr_stb,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    logic scl_meta_ff, scl_s_ff, scl_d_ff;
    logic sda_meta_ff, sda_s_ff, sda_d_ff;
    cal_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh;
    logic [7:0] ptr_ff, nxt_ptr;
    logic rw_ff, nxt_rw;
    logic first_ff, nxt_first;
    logic oe_n_ff, nxt_oe_n;
    logic busy_ff, nxt_busy;
    logic wr_ff, nxt_wr;
    logic [7:0] wa_ff, nxt_wa;
    logic [7:0] wd_ff, nxt_wd;

    wire scl_rise = scl_s_ff & ~scl_d_ff;
    wire scl_fall = ~scl_s_ff & scl_d_ff;
    wire start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
    wire stop_det = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
    wire byte_done = (cnt_ff == BIT_COUNT_BYTE);
    wire addr_hit = (sh_ff[7:1] == SLAVE_ADDR);

    assign sda_oe_n = oe_n_ff;
    assign busy = busy_ff;
    assign wr_stb = wr_ff;
    assign wr_addr = wa_ff;
    assign wr_data = wd_ff;
    assign rd_addr = ptr_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_ptr = ptr_ff;
        nxt_rw = rw_ff;
        nxt_first = first_ff;
        nxt_oe_n = oe_n_ff;
        nxt_busy = busy_ff;
        nxt_wr = 1'b0;
        nxt_wa = wa_ff;
        nxt_wd = wd_ff;
        if (stop_det) begin
            nxt_state = ST_IDLE;
            nxt_oe_n = 1'b1;
            nxt_busy = 1'b0;
        end else if (start_det) begin
            nxt_state = ST_ADDR;
            nxt_cnt = 4'h0;
            nxt_oe_n = 1'b1;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise && !byte_done) begin
                        nxt_sh = {sh_ff[6:0], sda_s_ff};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        nxt_state = ST_ACK;
                        nxt_oe_n = 1'b0;
                        if (state_ff == ST_ADDR) begin
                            if (addr_hit) begin
                                nxt_rw = sh_ff[0];
                                nxt_first = ~sh_ff[0];
                                nxt_busy = 1'b1;
                            end else begin
                                nxt_state = ST_IDLE;
                                nxt_oe_n = 1'b1;
                            end
                        end else if (first_ff) begin
                            nxt_ptr = sh_ff;
                            nxt_first = 1'b0;
                        end else begin
                            nxt_wr = 1'b1;
                            nxt_wa = ptr_ff;
                            nxt_wd = sh_ff;
                            nxt_ptr = ptr_ff + 8'h01;
                        end
                    end
                end
                ST_ACK, ST_RACK: begin
                    if (scl_rise && state_ff == ST_RACK && sda_s_ff) begin
                        nxt_state = ST_IDLE;
                    end else if (scl_fall) begin
                        nxt_cnt = rw_ff ? 4'h1 : 4'h0;
                        if (rw_ff) begin
                            nxt_state = ST_RD;
                            nxt_sh = rd_data;
                            nxt_oe_n = rd_data[7];
                            nxt_ptr = ptr_ff + 8'h01;
                        end else begin
                            nxt_state = ST_WR;
                            nxt_oe_n = 1'b1;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_fall && byte_done) begin
                        nxt_state = ST_RACK;
                        nxt_oe_n = 1'b1;
                    end else if (scl_fall) begin
                        nxt_sh = {sh_ff[6:0], 1'b0};
                        nxt_oe_n = sh_ff[6];
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {scl_meta_ff, scl_s_ff, scl_d_ff} <= 3'h7;
            {sda_meta_ff, sda_s_ff, sda_d_ff} <= 3'h7;
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            first_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            busy_ff <= 1'b0;
            wr_ff <= 1'b0;
            wa_ff <= 8'h00;
            wd_ff <= 8'h00;
        end else begin
            {scl_meta_ff, scl_s_ff, scl_d_ff} <= {scl_in, scl_meta_ff, scl_s_ff};
            {sda_meta_ff, sda_s_ff, sda_d_ff} <= {sda_in, sda_meta_ff, sda_s_ff};
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            ptr_ff <= nxt_ptr;
            rw_ff <= nxt_rw;
            first_ff <= nxt_first;
            oe_n_ff <= nxt_oe_n;
            busy_ff <= nxt_busy;
            wr_ff <= nxt_wr;
            wa_ff <= nxt_wa;
            wd_ff <= nxt_wd;
        end
    end
endmodule
`default_nettype wire

// >>> test/cal_i2c_host.sv
// serial-bus host model: drives the bus clock and pulls data low
`default_nettype none
module cal_i2c_host (
    // clock
    input wire logic clk,
    // bus
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // a third of a bit period, keeps the low phase well over eight clocks
    task automatic hp;
        repeat (10) @(posedge clk);
        #1;
    endtask
    // also a repeated start when entered with the clock low
    task automatic start;
        sda_low = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda_low = 1'b1;
        hp();
        scl = 1'b0;
        hp();
    endtask
    task automatic stop;
        sda_low = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_low = 1'b0;
        hp();
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        hp();
        scl = 1'b1;
        hp();
        r = sda;
        scl = 1'b0;
        hp();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, nak);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// >>> test/cal_rtc_sva.sv
// assertion checker for the calendar and alarm core ports
`default_nettype none
module cal_rtc_sva (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus and timebase
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic tick_1hz,
    // alarm
    input wire logic alarm_irq_enable,
    input wire logic alarm_flag_clear,
    input wire logic alarm_flag,
    input wire logic int_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    // cycles since a tick rise or bus clock fall, saturating
    logic [3:0] since_evt_ff;
    logic [3:0] nxt_since_evt;
    logic tick_ff;
    logic scl_ff;
    wire evt = (tick_1hz && !tick_ff) || (!scl_in && scl_ff);
    assign nxt_since_evt = evt ? 4'h0 : since_evt_ff + {3'h0, since_evt_ff != 4'hF};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            since_evt_ff <= 4'hF;
            tick_ff <= 1'b0;
            scl_ff <= 1'b1;
        end else begin
            since_evt_ff <= nxt_since_evt;
            tick_ff <= tick_1hz;
            scl_ff <= scl_in;
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence held_low;
        !sda_oe_n [*4];
    endsequence
    open_drain_a:
        assert property (sda_out == 1'b0) else $error("data pin driven high");
    oe_scl_low_a:
        assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2)) else $error("data moved in clock high");
    ack_hold_a:
        assert property ($fell(sda_oe_n) |=> held_low) else $error("data drive released early");
    int_follow_a:
        assert property (int_n == !($past(alarm_irq_enable) && alarm_flag)) else $error("interrupt off flag");
    int_quiet_a:
        assert property (!alarm_irq_enable |=> int_n) else $error("interrupt while disabled");
    flag_sticky_a:
        assert property (alarm_flag && !alarm_flag_clear |=> alarm_flag) else $error("flag dropped by itself");
    flag_cause_a:
        assert property ($rose(alarm_flag) |-> since_evt_ff < 4'hC) else $error("flag rose without cause");
    reset_quiet_a:
        assert property ($rose(reset_n) |-> sda_oe_n && int_n && !alarm_flag) else $error("outputs busy at reset");
endmodule
bind cal_rtc cal_rtc_sva u_sva (
    .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .tick_1hz(tick_1hz), .alarm_irq_enable(alarm_irq_enable), .alarm_flag_clear(alarm_flag_clear),
    .alarm_flag(alarm_flag), .int_n(int_n));
`default_nettype wire

// >>> test/cal_rtc_test.sv
// self-checking bench for the calendar and alarm core
`default_nettype none
module cal_rtc_test
    import cal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic tick_1hz = 1'b0;
    logic hour_mode_12 = 1'b0;
    logic alarm_irq_enable = 1'b0;
    logic alarm_flag_clear = 1'b0;
    logic sda_out, sda_oe_n, alarm_flag, int_n, scl, host_low;
    wire sda_bus;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    // pull-up wins unless someone pulls low
    assign sda_bus = !host_low && (sda_oe_n || sda_out);
    always #10 clk = ~clk;
    cal_rtc u_dut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .tick_1hz(tick_1hz), .hour_mode_12(hour_mode_12),
        .alarm_irq_enable(alarm_irq_enable), .alarm_flag_clear(alarm_flag_clear),
        .alarm_flag(alarm_flag), .int_n(int_n));
    cal_i2c_host u_host (.clk(clk), .sda(sda_bus), .scl(scl), .sda_low(host_low));
    ////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 50000) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t read %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t bit %b want %b", $time, got, exp);
        end
    endtask
    task automatic tick_once;
        repeat (5) @(posedge clk);
        #1 tick_1hz = 1'b1;
        repeat (5) @(posedge clk);
        #1 tick_1hz = 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic point(input logic [7:0] p);
        logic nak;
        u_host.start();
        u_host.wbyte({SLAVE_ADDR, 1'b0}, nak);
        chk1(nak, 1'b0);
        u_host.wbyte(p, nak);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
        logic nak;
        point(p);
        foreach (d[i]) u_host.wbyte(d[i], nak);
        u_host.stop();
    endtask
    task automatic rdchk(input logic [7:0] p, input logic [7:0] exp[$]);
        logic nak;
        logic [7:0] b;
        point(p);
        u_host.start();
        u_host.wbyte({SLAVE_ADDR, 1'b1}, nak);
        foreach (exp[i]) begin
            u_host.rbyte(i == exp.size() - 1, b);
            chk8(b, exp[i]);
        end
        u_host.stop();
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        logic nak;
        // a foreign address must stay unanswered
        u_host.start();
        u_host.wbyte({SLAVE_ADDR ^ 7'h01, 1'b0}, nak);
        chk1(nak, 1'b1);
        u_host.stop();
        rdchk(8'h04, '{8'h80, 8'h00, 8'h00, 8'h01, 8'h06, 8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h00});
    endtask
    task automatic t_rollover;
        wr(8'h04, '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99});
        tick_once();
        rdchk(8'h04, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
        wr(8'h09, '{8'hF1});
        rdchk(8'h09, '{8'h11});
    endtask
    // two ticks inside one access: one kept, one lost
    task automatic t_block;
        logic nak;
        logic [7:0] b;
        wr(8'h04, '{8'h00});
        point(8'h04);
        tick_once();
        tick_once();
        u_host.start();
        u_host.wbyte({SLAVE_ADDR, 1'b1}, nak);
        u_host.rbyte(1'b1, b);
        chk8(b, 8'h00);
        u_host.stop();
        rdchk(8'h04, '{8'h01});
    endtask
    task automatic t_alarm;
        alarm_irq_enable = 1'b1;
        wr(8'h04, '{8'h10});
        wr(8'h0B, '{8'h91});
        tick_once();
        chk1(alarm_flag, 1'b0);
        wr(8'h0B, '{8'h12});
        tick_once();
        chk1(alarm_flag, 1'b1);
        chk1(int_n, 1'b0);
        alarm_irq_enable = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk1(int_n, 1'b1);
        alarm_irq_enable = 1'b1;
        alarm_flag_clear = 1'b1;
        @(posedge clk);
        #1 alarm_flag_clear = 1'b0;
        repeat (4) @(posedge clk);
        #1 chk1(alarm_flag, 1'b0);
        tick_once();
        chk1(alarm_flag, 1'b0);
        hour_mode_12 = 1'b1;
        wr(8'h0B, '{8'h80, 8'h80, 8'h32});
        wr(8'h04, '{8'h59, 8'h59, 8'h11});
        tick_once();
        chk1(alarm_flag, 1'b1);
        rdchk(8'h06, '{8'h32});
        // 11 PM rolls to 12 AM and carries into the day and weekday
        wr(8'h04, '{8'h59, 8'h59, 8'h31});
        tick_once();
        rdchk(8'h04, '{8'h00, 8'h00, 8'h12, 8'h02, 8'h01});
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_defaults();
        t_rollover();
        t_block();
        t_alarm();
        results();
    end
endmodule
`default_nettype wire
